// ### lio_params.svh
// Purpose: Constants of the latched i/o port controller: offsets, fields, resets, timing.
// Assumes: A 50 MHz system clock.
// Notes:   Times are in nanoseconds; cycle counts are derived from them.
`ifndef LIO_PARAMS_SVH
`define LIO_PARAMS_SVH

// ------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ------------------------------------------------------------------
`define LIO_REG_CTRL      8'h00
`define LIO_REG_TXDATA    8'h04
`define LIO_REG_RXDATA    8'h08
`define LIO_REG_STATUS    8'h0c
`define LIO_REG_IRQ_STAT  8'h10
`define LIO_REG_IRQ_MASK  8'h14

// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define LIO_CTRL_OP_LSB   0
`define LIO_CTRL_OP_MSB   2
`define LIO_CTRL_GO       8
`define LIO_CTRL_STB_IDLE 9
`define LIO_CTRL_DIR_IDLE 10
`define LIO_STAT_BUSY     0
`define LIO_STAT_DEV_REQ  1
`define LIO_STAT_IRQ      2
`define LIO_IRQ_DONE      0
`define LIO_IRQ_DEV       1
`define LIO_IRQ_BITS      2
`define LIO_MASK_RST      2'h0
`define LIO_TX_RST        8'h00
`define LIO_RX_RST        8'h00

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define LIO_CLK_NS        20
`define LIO_PULSE_NS      30
`define LIO_SETUP_NS      15
`define LIO_HOLD_NS       20
`define LIO_OUTEN_NS      45
`define LIO_SYNC_STAGES   2
`define LIO_CEIL_CYC(ns)  (((ns) + `LIO_CLK_NS - 1) / `LIO_CLK_NS)
`define LIO_PULSE_CYC     `LIO_CEIL_CYC(`LIO_PULSE_NS)
`define LIO_SETUP_CYC     `LIO_CEIL_CYC(`LIO_SETUP_NS)
`define LIO_HOLD_CYC      `LIO_CEIL_CYC(`LIO_HOLD_NS)
`define LIO_READ_CYC      (`LIO_CEIL_CYC(`LIO_OUTEN_NS) + `LIO_SYNC_STAGES + 1)

`endif

// ### lio_pkg.sv
// Purpose: Types shared by the latched i/o port controller.
// Assumes: Nothing beyond the parameter header.
// Notes:   Operation codes follow declaration order, 0 to 4.
package lio_pkg;

    typedef enum logic [2:0] {
        LIO_OP_WRITE,
        LIO_OP_READ,
        LIO_OP_STROBE,
        LIO_OP_CLEAR,
        LIO_OP_BUFFER
    } lio_op_t;

    typedef enum logic [2:0] {
        LIO_ST_IDLE,
        LIO_ST_SETUP,
        LIO_ST_ACTIVE,
        LIO_ST_HOLD
    } lio_state_t;

    typedef struct packed {
        logic [7:0] port_data_in;
        logic       select_low_n;
        logic       select_high;
        logic       direction_mode;
        logic       input_strobe;
        logic       latch_clear_n;
    } lio_pins_t;

endpackage

// ### lio_sync2.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clk_in.
// Notes:   The first stage feeds only the second.
module lio_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    input  wire logic [W-1:0] rst_val_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb
    begin
        meta_d = d_in;
        sync_d = meta_q;
    end

    // Reset value is a constant: both flops start at zero, q_out at rst_val_in, and
    // the caller inverts active-low pins before them.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q_out = sync_q ^ rst_val_in;
endmodule

// ### lio_timer.sv
// Purpose: Down counter that times each phase of a pin sequence.
// Assumes: load_in is a one-cycle pulse at the start of a phase.
// Notes:   done_out is high once the loaded count has run out.
module lio_timer (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       load_in,
    input  wire logic [7:0] load_val_in,
    output logic            done_out
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    always_comb
    begin
        cnt_d = cnt_q;
        if (load_in)
        begin
            cnt_d = load_val_in;
        end
        else if (cnt_q != 8'h00)
        begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_q <= 8'h00;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    assign done_out = (cnt_q == 8'h00);
endmodule

// ### lio_ctrl.sv
// Purpose: APB-controlled host that drives an eight-bit latched i/o port through its pins.
// Assumes: 50 MHz sys_clk_in; the port's interrupt and data outputs are asynchronous.
// Notes:   One pin operation at a time; a start while busy is ignored.
//
// How it works
// RL1: Port latch follows data while gated.
// RL2: Low clear empties latch; gate wins.
// RL3: Latched data drives three-state outputs; the port model shows the inverse of the last driven byte while they are off.
// RL4: Selected only when low-select low, high-select high.
// RL5: Selection enables outputs, sets request flip-flop.
// RL6: Output mode: always enabled, select gates latch.
// RL7: Input mode: select enables, strobe gates latch.
// RL8: Strobe falling edge resets request flip-flop.
// RL9: Clear low sets request flip-flop, no interrupt.
// RL10: Interrupt low when flip-flop reset, unselected.
// RL11: Gated buffer: mode low, strobe high.
// RL12: Strobe in, interrupt, then select to read.
// RL13: Back-to-back ports share one direction control.
// RL14: Acknowledge selects port to place restart opcode.
// RL15: Output port latches bus data on select.
// RL16: Status latch: mode high, sync selects.
// RL17: Sample port inputs into clock domain.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`include "lio_params.svh"

module lio_ctrl
    import lio_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             irq_out,
    input  wire logic [7:0]  port_data_out_in,
    input  wire logic        port_int_n_in,
    output logic      [7:0]  port_data_in_out,
    output logic             select_low_n_out,
    output logic             select_high_out,
    output logic             direction_mode_out,
    output logic             input_strobe_out,
    output logic             latch_clear_n_out
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    function automatic logic [7:0] cyc_load(input int unsigned cyc);
        return 8'(cyc - 1);
    endfunction

    function automatic logic is_read(input lio_op_t op);
        return (op == LIO_OP_READ) || (op == LIO_OP_BUFFER);
    endfunction

    // ------------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------------
    logic [7:0] data_s;
    logic       int_s;
    logic       int_prev_q;
    logic       dev_ev;

    lio_sync2 #(.W(8)) u_sync_data (
        .clk_in     (sys_clk_in),
        .rst_n_in   (rst_n_q),
        .d_in       (port_data_out_in),
        .rst_val_in (8'h00),
        .q_out      (data_s)
    );

    // The interrupt pin idles high, so it is synchronised inverted.
    lio_sync2 #(.W(1)) u_sync_int (
        .clk_in     (sys_clk_in),
        .rst_n_in   (rst_n_q),
        .d_in       (~port_int_n_in),
        .rst_val_in (1'b1),
        .q_out      (int_s)
    ); // [RL17]

    assign dev_ev = int_prev_q & ~int_s; // [RL12]

    // ------------------------------------------------------------------
    // Registers and APB slave
    // ------------------------------------------------------------------
    logic        pready_q, pready_d;
    logic        slverr_q, slverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [7:0]  tx_q, tx_d;
    logic        stb_idle_q, stb_idle_d;
    logic        dir_idle_q, dir_idle_d;
    logic [1:0]  mask_q, mask_d;
    logic [1:0]  stat_q, stat_d;
    logic        irq_q, irq_d;
    logic        go_req;
    lio_op_t     go_op;
    logic        done_ev;
    logic [7:0]  rx_q, rx_d;
    lio_state_t  st_q, st_d;
    logic        acc;
    logic        wr;
    logic [1:0]  ev;

    assign acc = psel_in & penable_in & pready_q;
    assign wr  = acc & pwrite_in;
    assign ev  = {dev_ev, done_ev};
    assign go_op = lio_op_t'(pwdata_in[`LIO_CTRL_OP_MSB:`LIO_CTRL_OP_LSB]);
    assign go_req = wr && (paddr_in == `LIO_REG_CTRL) && pwdata_in[`LIO_CTRL_GO]
                    && (go_op <= LIO_OP_BUFFER) && (st_q == LIO_ST_IDLE);

    always_comb
    begin
        pready_d   = psel_in & penable_in & ~pready_q;
        slverr_d   = 1'b0;
        prdata_d   = prdata_q;
        tx_d       = tx_q;
        stb_idle_d = stb_idle_q;
        dir_idle_d = dir_idle_q;
        mask_d     = mask_q;
        stat_d     = stat_q;
        if (pready_d)
        begin
            prdata_d = 32'h0000_0000;
            unique case (paddr_in)
                `LIO_REG_CTRL:     prdata_d[`LIO_CTRL_DIR_IDLE:`LIO_CTRL_STB_IDLE] =
                                       {dir_idle_q, stb_idle_q};
                `LIO_REG_TXDATA:   prdata_d[7:0] = tx_q;
                `LIO_REG_RXDATA:   prdata_d[7:0] = rx_q;
                `LIO_REG_STATUS:   prdata_d[`LIO_STAT_IRQ:`LIO_STAT_BUSY] =
                                       {irq_q, ~int_s, st_q != LIO_ST_IDLE};
                `LIO_REG_IRQ_STAT: prdata_d[1:0] = stat_q;
                `LIO_REG_IRQ_MASK: prdata_d[1:0] = mask_q;
                default:           slverr_d = 1'b1;
            endcase
        end
        if (wr)
        begin
            unique case (paddr_in)
                `LIO_REG_CTRL:
                begin
                    stb_idle_d = pwdata_in[`LIO_CTRL_STB_IDLE];
                    dir_idle_d = pwdata_in[`LIO_CTRL_DIR_IDLE];
                end
                `LIO_REG_TXDATA:   tx_d = pwdata_in[7:0];
                `LIO_REG_IRQ_MASK: mask_d = pwdata_in[1:0];
                default:           ;
            endcase
        end
        // Only the bits that the read returned are cleared, and a new event wins.
        if (acc && !pwrite_in && paddr_in == `LIO_REG_IRQ_STAT)
        begin
            stat_d = stat_q & ~prdata_q[1:0];
        end
        stat_d = stat_d | ev;
        irq_d  = |(stat_q & mask_q);
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pready_q   <= 1'b0;
            slverr_q   <= 1'b0;
            prdata_q   <= 32'h0000_0000;
            tx_q       <= `LIO_TX_RST;
            stb_idle_q <= 1'b0;
            dir_idle_q <= 1'b0;
            mask_q     <= `LIO_MASK_RST;
            stat_q     <= 2'h0;
            irq_q      <= 1'b0;
            int_prev_q <= 1'b1;
        end
        else
        begin
            pready_q   <= pready_d;
            slverr_q   <= slverr_d;
            prdata_q   <= prdata_d;
            tx_q       <= tx_d;
            stb_idle_q <= stb_idle_d;
            dir_idle_q <= dir_idle_d;
            mask_q     <= mask_d;
            stat_q     <= stat_d;
            irq_q      <= irq_d;
            int_prev_q <= int_s;
        end
    end

    // ------------------------------------------------------------------
    // Pin sequencer
    // ------------------------------------------------------------------
    lio_op_t    op_q, op_d;
    lio_pins_t  pins_q, pins_d;
    logic       tmr_load;
    logic [7:0] tmr_val;
    logic       tmr_done;

    lio_timer u_timer (
        .clk_in      (sys_clk_in),
        .rst_n_in    (rst_n_q),
        .load_in     (tmr_load),
        .load_val_in (tmr_val),
        .done_out    (tmr_done)
    );

    always_comb
    begin
        st_d     = st_q;
        op_d     = op_q;
        pins_d   = pins_q;
        rx_d     = rx_q;
        tmr_load = 1'b0;
        tmr_val  = 8'h00;
        done_ev  = 1'b0;
        unique case (st_q)
            LIO_ST_IDLE:
            begin
                pins_d.select_low_n   = 1'b1;
                pins_d.select_high    = 1'b0;
                pins_d.latch_clear_n  = 1'b1;
                pins_d.input_strobe   = stb_idle_q;
                pins_d.direction_mode = dir_idle_q; // [RL16]
                if (go_req)
                begin
                    op_d                  = go_op;
                    pins_d.port_data_in   = tx_q;
                    // Writes latch on select; everything else gates on the strobe.
                    pins_d.direction_mode = (go_op == LIO_OP_WRITE); // [RL15]
                    if (go_op == LIO_OP_BUFFER)
                    begin
                        pins_d.input_strobe = 1'b1; // [RL11]
                    end
                    st_d     = LIO_ST_SETUP;
                    tmr_load = 1'b1;
                    tmr_val  = cyc_load(`LIO_SETUP_CYC);
                end
            end
            LIO_ST_SETUP:
            begin
                if (tmr_done)
                begin
                    unique case (op_q)
                        LIO_OP_STROBE: pins_d.input_strobe  = 1'b1;
                        LIO_OP_CLEAR:  pins_d.latch_clear_n = 1'b0;
                        default:
                        begin
                            pins_d.select_low_n = 1'b0; // [RL13]
                            pins_d.select_high  = 1'b1; // [RL14]
                        end
                    endcase
                    st_d     = LIO_ST_ACTIVE;
                    tmr_load = 1'b1;
                    tmr_val  = is_read(op_q) ? cyc_load(`LIO_READ_CYC)
                                             : cyc_load(`LIO_PULSE_CYC);
                end
            end
            LIO_ST_ACTIVE:
            begin
                if (tmr_done)
                begin
                    if (is_read(op_q))
                    begin
                        rx_d = data_s; // [RL12]
                    end
                    pins_d.select_low_n  = 1'b1;
                    pins_d.select_high   = 1'b0;
                    pins_d.latch_clear_n = 1'b1;
                    // Data stays put while the strobe falls, so the port keeps it.
                    pins_d.input_strobe  = (op_q == LIO_OP_BUFFER); // [RL12]
                    st_d     = LIO_ST_HOLD;
                    tmr_load = 1'b1;
                    tmr_val  = cyc_load(`LIO_HOLD_CYC);
                end
            end
            LIO_ST_HOLD:
            begin
                if (tmr_done)
                begin
                    done_ev = 1'b1;
                    st_d    = LIO_ST_IDLE;
                end
            end
            default:
            begin
                st_d = LIO_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            st_q   <= LIO_ST_IDLE;
            op_q   <= LIO_OP_WRITE;
            pins_q <= '{port_data_in: 8'h00, select_low_n: 1'b1, select_high: 1'b0,
                        direction_mode: 1'b0, input_strobe: 1'b0, latch_clear_n: 1'b1};
            rx_q   <= `LIO_RX_RST;
        end
        else
        begin
            st_q   <= st_d;
            op_q   <= op_d;
            pins_q <= pins_d;
            rx_q   <= rx_d;
        end
    end

    assign prdata_out         = prdata_q;
    assign pready_out         = pready_q;
    assign pslverr_out        = slverr_q;
    assign irq_out            = irq_q;
    assign port_data_in_out   = pins_q.port_data_in;
    assign select_low_n_out   = pins_q.select_low_n;
    assign select_high_out    = pins_q.select_high;
    assign direction_mode_out = pins_q.direction_mode;
    assign input_strobe_out   = pins_q.input_strobe;
    assign latch_clear_n_out  = pins_q.latch_clear_n;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_BUFFER_PINS: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // [RL11]
        (st_q == LIO_ST_ACTIVE && op_q == LIO_OP_BUFFER)
        |-> (input_strobe_out && !direction_mode_out && !select_low_n_out))
        else $error("buffer read without strobe high and mode low");
    AST_WRITE_MODE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // [RL15]
        (st_q != LIO_ST_IDLE && op_q == LIO_OP_WRITE) |-> direction_mode_out)
        else $error("write sequence without output mode");
    AST_STROBE_DATA: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // [RL12]
        ($fell(input_strobe_out) && st_q == LIO_ST_HOLD)
        |-> ($stable(port_data_in_out) ##1 $stable(port_data_in_out)))
        else $error("data moved around the strobe falling edge");
    AST_SELECT_WIDTH: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // [RL13]
        $rose(select_high_out) |-> (select_high_out && !select_low_n_out)[*2])
        else $error("select pulse shorter than two cycles");
    AST_CLEAR_WIDTH: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // [RL14]
        $fell(latch_clear_n_out) |-> !latch_clear_n_out ##1 !latch_clear_n_out ##1
        latch_clear_n_out)
        else $error("clear pulse not two cycles");
    AST_IRQ_LEVEL: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // [RL12]
        ##1 (irq_out == |($past(stat_q) & $past(mask_q))))
        else $error("interrupt output does not follow masked status");
    AST_GO_BUSY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // [RL16]
        go_req |=> (st_q == LIO_ST_SETUP) ##[1:3] (st_q == LIO_ST_ACTIVE))
        else $error("accepted start did not reach the active phase");
    AST_DEV_EVENT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q) // [RL17]
        dev_ev |=> stat_q[`LIO_IRQ_DEV])
        else $error("port interrupt not recorded");
    AST_PREADY_ONE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_q)
        pready_out |=> !pready_out)
        else $error("pready held for more than one cycle");
endmodule

// ### lio_port_model.sv
// Purpose: Behavioural model of the eight-bit latched i/o port on the far side of the host.
// Assumes: Pins come straight from the host registers; no clock exists inside the port.
// Notes:   Released outputs show the inverse of the last driven byte, never a held value.
module lio_port_model
    import lio_pkg::*;
(
    input  wire lio_pins_t  pins_in,
    output logic [7:0]      port_data_out_out,
    output logic            int_n_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] latch_q = 8'h00;
    logic [7:0] last_q  = 8'h00;
    logic       service_request_ff = 1'b1;
    logic       prev_stb = 1'b0;
    logic       sel;
    logic       gate;
    logic       en;
    logic       set_c;
    logic       stb;

    assign stb   = pins_in.input_strobe;
    assign sel   = !pins_in.select_low_n && pins_in.select_high;
    assign gate  = pins_in.direction_mode ? sel : stb;
    assign en    = pins_in.direction_mode || sel;
    assign set_c = sel || !pins_in.latch_clear_n;

    // The gate is tested first so that it wins over a clear held at the same time.
    always @*
    begin
        if (gate)
            latch_q = pins_in.port_data_in;
        else if (!pins_in.latch_clear_n)
            latch_q = 8'h00;
    end

    // Only a clean high-to-low step counts, so the x-to-0 step at start-up is ignored.
    always @(stb or set_c)
    begin
        if (set_c)
            service_request_ff = 1'b1;
        else if (prev_stb === 1'b1 && stb === 1'b0)
            service_request_ff = 1'b0;
        prev_stb = stb;
    end

    assign int_n_out = !(!service_request_ff || sel);

    always @*
    begin
        if (en)
            last_q = latch_q;
        port_data_out_out = en ? latch_q : ~last_q;
    end
endmodule

// ### testbench.sv
// Purpose: Self-checking bench for the latched i/o port host controller.
// Assumes: The port model answers at once, well inside one clock.
// Notes:   Pin operations are awaited by polling busy, then a fixed ten clocks.
`include "lio_params.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD %0t got %h exp %h", $time, got, exp); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic              sys_clk = 1'b0;
    logic              rstn    = 1'b0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [7:0]        paddr   = 8'h00;
    logic [31:0]       pwdata  = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic [7:0]        pdo;
    logic              pint_n;
    logic [7:0]        pdi;
    logic              sel_n;
    logic              sel_h;
    logic              mode;
    logic              stb;
    logic              clr_n;
    lio_pkg::lio_pins_t pins;
    int                fail_count  = 0;
    int                checks_done = 0;

    assign pins = {pdi, sel_n, sel_h, mode, stb, clr_n};

    lio_ctrl uut (.sys_clk_in(sys_clk), .rstn_in(rstn), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq), .port_data_out_in(pdo),
        .port_int_n_in(pint_n), .port_data_in_out(pdi), .select_low_n_out(sel_n),
        .select_high_out(sel_h), .direction_mode_out(mode), .input_strobe_out(stb),
        .latch_clear_n_out(clr_n));

    lio_port_model port (.pins_in(pins), .port_data_out_out(pdo), .int_n_out(pint_n));

    initial forever #10 sys_clk = ~sys_clk;

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    // The request stands until the rising edge at which pready is seen high; only the
    // watchdog ends a wait that never gets an answer.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
    begin
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    end
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] v;
        logic        er;
    begin
        apb(1'b0, a, 32'h0, v, er);
        `CHK(v, e)
        `CHK(er, ee)
    end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        logic        er;
    begin
        apb(1'b1, a, d, v, er);
    end
    endtask

    task automatic run_op(input logic [2:0] op);
        logic [31:0] v;
        logic        er;
    begin
        wr(`LIO_REG_CTRL, 32'h0000_0100 | {29'h0, op});
        do
        begin
            apb(1'b0, `LIO_REG_STATUS, 32'h0, v, er);
        end while (v[`LIO_STAT_BUSY] !== 1'b0);
        repeat (10) @(posedge sys_clk);
    end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
    begin
        expect_reg(`LIO_REG_CTRL, 32'h0, 1'b0);
        expect_reg(`LIO_REG_STATUS, 32'h0, 1'b0);
        expect_reg(`LIO_REG_IRQ_MASK, 32'h0, 1'b0);
        expect_reg(8'h18, 32'h0, 1'b1);
        wr(`LIO_REG_TXDATA, 32'h0000_00a5);
        expect_reg(`LIO_REG_TXDATA, 32'h0000_00a5, 1'b0);
    end
    endtask

    // Selection pulls an idle port's interrupt low, so a selecting op flags bit 1 too.
    task automatic t_write_read;
    begin
        run_op(3'h0);
        expect_reg(`LIO_REG_IRQ_STAT, 32'h3, 1'b0);
        `CHK(irq, 1'b0)
        wr(`LIO_REG_TXDATA, 32'h0);
        run_op(3'h1);
        expect_reg(`LIO_REG_RXDATA, 32'h0000_00a5, 1'b0);
        expect_reg(`LIO_REG_IRQ_STAT, 32'h3, 1'b0);
    end
    endtask

    task automatic t_strobe;
    begin
        wr(`LIO_REG_IRQ_MASK, 32'h2);
        wr(`LIO_REG_TXDATA, 32'h0000_003c);
        run_op(3'h2);
        @(negedge sys_clk);
        `CHK(irq, 1'b1)
        expect_reg(`LIO_REG_STATUS, 32'h6, 1'b0);
        expect_reg(`LIO_REG_IRQ_STAT, 32'h3, 1'b0);
        repeat (3) @(negedge sys_clk);
        `CHK(irq, 1'b0)
        // New input data must not reach the output: the latch holds the strobed byte.
        wr(`LIO_REG_TXDATA, 32'h0);
        run_op(3'h1);
        expect_reg(`LIO_REG_RXDATA, 32'h0000_003c, 1'b0);
        // The port was already requesting, so the select raises no new edge.
        expect_reg(`LIO_REG_STATUS, 32'h0, 1'b0);
        expect_reg(`LIO_REG_IRQ_STAT, 32'h1, 1'b0);
        wr(`LIO_REG_IRQ_MASK, 32'h0);
    end
    endtask

    task automatic t_clear;
    begin
        wr(`LIO_REG_TXDATA, 32'h0000_0077);
        run_op(3'h2);
        expect_reg(`LIO_REG_IRQ_STAT, 32'h3, 1'b0);
        run_op(3'h3);
        expect_reg(`LIO_REG_STATUS, 32'h0, 1'b0);
        expect_reg(`LIO_REG_IRQ_STAT, 32'h1, 1'b0);
        run_op(3'h1);
        expect_reg(`LIO_REG_RXDATA, 32'h0, 1'b0);
        expect_reg(`LIO_REG_IRQ_STAT, 32'h3, 1'b0);
    end
    endtask

    // A second start while busy must be dropped, so the clear never reaches the latch.
    task automatic t_buffer_busy;
    begin
        wr(`LIO_REG_TXDATA, 32'h0000_005a);
        run_op(3'h4);
        expect_reg(`LIO_REG_RXDATA, 32'h0000_005a, 1'b0);
        wr(`LIO_REG_CTRL, 32'h0000_0101);
        wr(`LIO_REG_CTRL, 32'h0000_0103);
        // The first call lands while the read is still busy and is dropped too.
        run_op(3'h1);
        run_op(3'h1);
        expect_reg(`LIO_REG_RXDATA, 32'h0000_005a, 1'b0);
        wr(`LIO_REG_CTRL, 32'h0000_0600);
        expect_reg(`LIO_REG_CTRL, 32'h0000_0600, 1'b0);
        `CHK({stb, mode}, 2'b11)
        `CHK(pdo, 8'h5a)
    end
    endtask

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic report_and_stop;
    begin
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask

    initial
    begin
        #400000;
        fail_count++;
        $display("BAD %0t watchdog ran out", $time);
        report_and_stop();
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_regs();
        t_write_read();
        t_strobe();
        t_clear();
        t_buffer_busy();
        report_and_stop();
    end
endmodule
